/* File: design/irq_status_and_id_regs.sv */
`timescale 1ns/1ps
`include "irq_id_consts.svh"

module irq_status_and_id_regs
    import irq_id_pkg::*;
#(
    // Arbitrary neutral identification string, not a real part code
    parameter ident_type IDENT_STRING = 48'h5157_5859_5A37
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_resetn,
    input  wire logic         i_clk_en,
    input  wire logic [7:0]   i_reg_addr,
    input  wire logic         i_reg_wr,
    input  wire logic         i_reg_rd,
    input  wire logic [7:0]   i_reg_wdata,
    input  wire logic         i_downstream_irq,
    output logic [7:0]        o_reg_rdata,
    output logic              o_reg_rvalid,
    output logic              o_irq
);

    // ********************************
    // Storage
    // ********************************
    reg_byte_type irq_control;
    reg_byte_type irq_status;
    logic         downstream_meta;
    logic         downstream_sync;

    // ********************************
    // Decode
    // ********************************
    function automatic reg_byte_type ident_char(input logic [2:0] idx);
        ident_char = IDENT_STRING[8'(47 - 8 * idx) -: 8];
    endfunction

    wire          hit_control = (i_reg_addr == `ADDR_IRQ_CONTROL);
    wire          hit_status  = (i_reg_addr == `ADDR_IRQ_STATUS);
    wire          hit_ident   = (i_reg_addr >= `ADDR_IDENT_BYTE0) && (i_reg_addr <= `ADDR_IDENT_BYTE5);
    wire [2:0]    ident_index = 3'(i_reg_addr - `ADDR_IDENT_BYTE0);

    // Only the control register takes writes; reserved bits never store
    wire          ctrl_write   = i_reg_wr && hit_control;
    wire [7:0]    next_control = ctrl_write ? (i_reg_wdata & `CTRL_WRITE_MASK) : irq_control;

    wire          downstream_enabled = downstream_sync && irq_control[`BIT_DOWNSTREAM_ENABLE];

    wire [7:0]    next_status = {2'b00,
                                 downstream_sync,
                                 4'b0000,
                                 downstream_enabled};

    // Source enable gates too, so a stale pending bit cannot leak out for a cycle after disable
    wire          next_irq = irq_status[`BIT_GLOBAL_PENDING] && irq_control[`BIT_GLOBAL_ENABLE]
                             && irq_control[`BIT_DOWNSTREAM_ENABLE];

    wire [7:0]    next_rdata = hit_control ? irq_control :
                               hit_status  ? irq_status  :
                               hit_ident   ? ident_char(ident_index) :
                                             `REG_RESET_VALUE;

    // ********************************
    // Synchroniser
    // ********************************
    // Receiver line is asynchronous to this clock
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            downstream_meta <= 1'b0;
            downstream_sync <= 1'b0;
        end else if (i_clk_en) begin
            downstream_meta <= i_downstream_irq;
            downstream_sync <= downstream_meta;
        end
    end

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_control <= `REG_RESET_VALUE;
            irq_status  <= `REG_RESET_VALUE;
            o_irq       <= 1'b0;
        end else if (i_clk_en) begin
            irq_control <= next_control;
            irq_status  <= next_status;
            o_irq       <= next_irq;
        end
    end

    // Read data valid one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reg_rdata  <= `REG_RESET_VALUE;
            o_reg_rvalid <= 1'b0;
        end else if (i_clk_en) begin
            o_reg_rdata  <= i_reg_rd ? next_rdata : o_reg_rdata;
            o_reg_rvalid <= i_reg_rd;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    a_irq_needs_enable: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && !irq_control[`BIT_GLOBAL_ENABLE]) |=> !o_irq
    ) else $error("Interrupt driven while global enable is clear");

    a_irq_follows_pending: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_clk_en ##1 i_clk_en |=> o_irq == ($past(irq_control[`BIT_GLOBAL_ENABLE])
                                           & $past(irq_control[`BIT_DOWNSTREAM_ENABLE])
                                           & $past(downstream_sync, 2)
                                           & $past(irq_control[`BIT_DOWNSTREAM_ENABLE], 2))
    ) else $error("Interrupt output does not follow enabled pending source");

    a_downstream_flag: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_clk_en |=> irq_status[`BIT_DOWNSTREAM_FLAG] == $past(downstream_sync)
    ) else $error("Downstream flag does not track the receiver request");

    a_global_pending: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && downstream_sync && irq_control[5]) |=> irq_status[`BIT_GLOBAL_PENDING]
    ) else $error("Global pending flag missing for enabled source");

    a_ident_readback: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && i_reg_rd && i_reg_addr == `ADDR_IDENT_BYTE0) |=>
            (o_reg_rvalid && o_reg_rdata == IDENT_STRING[47:40])
    ) else $error("First identification byte read back wrong");

    a_reserved_zero: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (irq_control[4:1] == 4'h0) && (irq_status[4:1] == 4'h0)
    ) else $error("Reserved bits hold a nonzero value");

    a_source_masked: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && !irq_control[`BIT_DOWNSTREAM_ENABLE]) |=> !irq_status[`BIT_GLOBAL_PENDING]
    ) else $error("Global flag set with downstream source disabled");

    a_write_ignored: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && i_reg_wr && !hit_control) |=> $stable(irq_control)
    ) else $error("Write outside control register changed control");

    a_control_write: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && i_reg_wr && hit_control) |=> irq_control == ($past(i_reg_wdata) & `CTRL_WRITE_MASK)
    ) else $error("Control write stored wrong bits");

    a_control_readback: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && i_reg_rd && hit_control) |=> o_reg_rdata == $past(irq_control)
    ) else $error("Control register read back wrong");

    a_status_readback: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && i_reg_rd && hit_status) |=> o_reg_rdata == $past(irq_status)
    ) else $error("Status register read back wrong");

    a_unmapped_zero: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && i_reg_rd && !hit_control && !hit_status && !hit_ident) |=> o_reg_rdata == `REG_RESET_VALUE
    ) else $error("Unmapped read returned nonzero data");

    a_upper_bits_zero: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (irq_control[7:6] == 2'b00) && (irq_status[7:6] == 2'b00)
    ) else $error("Upper reserved bits hold a nonzero value");

    a_rvalid_on_read: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && i_reg_rd) |=> o_reg_rvalid
    ) else $error("Read strobe not answered by valid");

    a_rvalid_single: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && !i_reg_rd) |=> !o_reg_rvalid
    ) else $error("Read valid without a read strobe");

    a_rdata_holds: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && !i_reg_rd) |=> $stable(o_reg_rdata)
    ) else $error("Read data changed without a read");

    a_frozen_regs: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        !i_clk_en |=> $stable(irq_control) && $stable(irq_status)
                      && $stable(downstream_meta) && $stable(downstream_sync)
    ) else $error("State moved while clock enable was low");

    a_frozen_outputs: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        !i_clk_en |=> $stable(o_irq) && $stable(o_reg_rvalid) && $stable(o_reg_rdata)
    ) else $error("Output moved while clock enable was low");

    a_sync_first_stage: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_clk_en |=> downstream_meta == $past(i_downstream_irq)
    ) else $error("Synchroniser first stage missed the receiver line");

    a_ident_byte1: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && i_reg_rd && i_reg_addr == `ADDR_IDENT_BYTE1) |=>
            (o_reg_rvalid && o_reg_rdata == IDENT_STRING[39:32])
    ) else $error("Second identification byte read back wrong");

    a_ident_byte2: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && i_reg_rd && i_reg_addr == `ADDR_IDENT_BYTE2) |=>
            (o_reg_rvalid && o_reg_rdata == IDENT_STRING[31:24])
    ) else $error("Third identification byte read back wrong");

    a_ident_byte3: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && i_reg_rd && i_reg_addr == `ADDR_IDENT_BYTE3) |=>
            (o_reg_rvalid && o_reg_rdata == IDENT_STRING[23:16])
    ) else $error("Fourth identification byte read back wrong");

    a_ident_byte4: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && i_reg_rd && i_reg_addr == `ADDR_IDENT_BYTE4) |=>
            (o_reg_rvalid && o_reg_rdata == IDENT_STRING[15:8])
    ) else $error("Fifth identification byte read back wrong");

    a_ident_byte5: assert property (
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_clk_en && i_reg_rd && i_reg_addr == `ADDR_IDENT_BYTE5) |=>
            (o_reg_rvalid && o_reg_rdata == IDENT_STRING[7:0])
    ) else $error("Sixth identification byte read back wrong");

endmodule

/* File: design/irq_id_consts.svh */
// Overview of operation
// - Control bit 0 is the global enable gating the interrupt output to the host.
// - Status bit 5 reads one while the downstream receiver signals an interrupt.
// - Status bit 0 is set while any individually enabled source is indicated.
// - Six read-only bytes return a fixed identification string, one character each.
// - Control bit 5 enables the downstream interrupt into the global flag.
`ifndef IRQ_ID_CONSTS_SVH
`define IRQ_ID_CONSTS_SVH

// ********************************
// Register offsets
// ********************************
`define ADDR_IRQ_CONTROL  8'hC6
`define ADDR_IRQ_STATUS   8'hC7
`define ADDR_IDENT_BYTE0  8'hF0
`define ADDR_IDENT_BYTE1  8'hF1
`define ADDR_IDENT_BYTE2  8'hF2
`define ADDR_IDENT_BYTE3  8'hF3
`define ADDR_IDENT_BYTE4  8'hF4
`define ADDR_IDENT_BYTE5  8'hF5

// ********************************
// Field positions and values
// ********************************
`define BIT_GLOBAL_ENABLE      0
`define BIT_GLOBAL_PENDING     0
`define BIT_DOWNSTREAM_ENABLE  5
`define BIT_DOWNSTREAM_FLAG    5
`define CTRL_WRITE_MASK        8'h21
`define REG_RESET_VALUE        8'h00
`define IDENT_BYTES            6

`endif

/* File: design/irq_id_pkg.sv */
package irq_id_pkg;
    typedef logic [7:0] reg_byte_type;
    typedef logic [47:0] ident_type;
endpackage

/* File: dv/host_model.sv */
`timescale 1ns/1ps
// ****************
// Register host
// ****************
module host_model (
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    output logic [7:0]      o_addr,
    output logic            o_wr,
    output logic            o_rd,
    output logic [7:0]      o_wdata
);
    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end
    // One-cycle strobe; released address and data lines show inverse so stale values never match
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic v);
        @(posedge i_sys_clk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr = w;
        o_rd = !w;
        @(posedge i_sys_clk);
        #1;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
        q = i_rdata;
        v = i_rvalid;
    endtask
endmodule

/* File: dv/tb_irq_status_and_id_regs.sv */
`timescale 1ns/1ps
module tb_irq_status_and_id_regs;
    import irq_id_pkg::*;
    localparam ident_type ID = 48'h4142_4344_4546; // Arbitrary code
    logic sys_clk = 0, resetn = 0, irq_in = 0, clk_en = 1, wr, rd_s, rvalid, irq;
    logic [7:0] addr, wdata, rdata;
    int bad_count = 0, cmp_count = 0;
    always #2.5 sys_clk = ~sys_clk;
    host_model i_host (.i_sys_clk(sys_clk), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_addr(addr), .o_wr(wr), .o_rd(rd_s), .o_wdata(wdata));
    irq_status_and_id_regs #(.IDENT_STRING(ID)) i_dut (.i_sys_clk(sys_clk), .i_resetn(resetn),
        .i_clk_en(clk_en), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd_s), .i_reg_wdata(wdata),
        .i_downstream_irq(irq_in), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_irq(irq));
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic v;
        i_host.access(1'b0, a, 8'h00, q, v);
        chk("rvalid", 8'h01, {7'h00, v});
        chk("rdata", e, q);
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic v;
        i_host.access(1'b1, a, d, q, v);
    endtask
    task settle(input int n, input logic e);
        repeat (n) @(posedge sys_clk);
        #1;
        chk("o_irq", {7'h00, e}, {7'h00, irq});
    endtask
    // ****************
    // Scenarios
    // ****************
    task test_ident();
        for (int i = 0; i < 6; i++) wr_reg(8'(8'hF0 + i), 8'hFF);
        for (int i = 0; i < 6; i++) rd(8'(8'hF0 + i), ID[47-8*i -: 8]);
        rd(8'h80, 8'h00);
        $display("test_ident done");
    endtask
    task test_ctrl();
        rd(8'hC6, 8'h00);
        wr_reg(8'hC6, 8'hFF);
        rd(8'hC6, 8'h21);
        wr_reg(8'hF0, 8'h00);
        chk("rdata_hold", 8'h21, rdata);
        chk("rvalid_low", 8'h00, {7'h00, rvalid});
        $display("test_ctrl done");
    endtask
    task test_irq();
        irq_in = 1'b1;
        settle(6, 1'b1);
        rd(8'hC7, 8'h21);
        wr_reg(8'hC6, 8'h20);
        settle(2, 1'b0);
        rd(8'hC7, 8'h21);
        wr_reg(8'hC6, 8'h01);
        settle(1, 1'b0); // Stale pending bit must not leak out
        settle(1, 1'b0); // Global enable without source enable keeps output low
        wr_reg(8'hC7, 8'hFF);
        rd(8'hC7, 8'h20);
        wr_reg(8'hC6, 8'h21);
        settle(3, 1'b1);
        irq_in = 1'b0;
        settle(6, 1'b0);
        rd(8'hC7, 8'h00);
        $display("test_irq done");
    endtask
    task test_freeze();
        logic [7:0] q;
        logic       v;
        @(posedge sys_clk);
        #1;
        clk_en = 1'b0;
        irq_in = 1'b1;
        wr_reg(8'hC6, 8'h00);
        i_host.access(1'b0, 8'hC6, 8'h00, q, v);
        chk("rvalid_frozen", 8'h00, {7'h00, v});
        chk("rdata_frozen", 8'h00, q);
        settle(6, 1'b0);
        clk_en = 1'b1;
        settle(6, 1'b1);
        rd(8'hC6, 8'h21);
        $display("test_freeze done");
    endtask
    task test_reset();
        @(posedge sys_clk);
        #1;
        resetn = 1'b0;
        #1;
        chk("o_irq_reset", 8'h00, {7'h00, irq});
        repeat (2) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        rd(8'hC6, 8'h00);
        settle(6, 1'b0);
        rd(8'hC7, 8'h20);
        irq_in = 1'b0;
        $display("test_reset done");
    endtask
    task final_report();
        $display("Compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 resetn = 1'b1;
        test_ident();
        test_ctrl();
        test_irq();
        test_freeze();
        test_reset();
        final_report();
    end
    // Run needs well under 100 cycles per access
    initial begin
        #20000;
        bad_count++;
        final_report();
    end
endmodule
